// ==== hdl/mpfc_consts.svh ====
`ifndef MPFC_CONSTS_SVH
`define MPFC_CONSTS_SVH

// Register byte addresses, one aligned 32-bit word each.
`define MPFC_ADDR_RX_PCP_TYPE 8'h00
`define MPFC_ADDR_RX_PCP_RANGE 8'h04
`define MPFC_ADDR_RX_GPP 8'h08
`define MPFC_ADDR_RX_PPP 8'h0c
`define MPFC_ADDR_CTRL 8'h10
`define MPFC_ADDR_RX_MCAST_LO 8'h14
`define MPFC_ADDR_RX_MCAST_HI 8'h18
`define MPFC_ADDR_TX_GPP_DA_LO 8'h1c
`define MPFC_ADDR_TX_GPP_DA_HI 8'h20
`define MPFC_ADDR_TX_GPP_SA_LO 8'h24
`define MPFC_ADDR_TX_GPP_SA_HI 8'h28
`define MPFC_ADDR_TX_GPP_TYPE 8'h2c
`define MPFC_ADDR_TX_PPP_DA_LO 8'h30
`define MPFC_ADDR_TX_PPP_DA_HI 8'h34
`define MPFC_ADDR_TX_PPP_SA_LO 8'h38
`define MPFC_ADDR_TX_PPP_SA_HI 8'h3c
`define MPFC_ADDR_TX_PPP_TYPE 8'h40
`define MPFC_ADDR_STATUS 8'h44
`define MPFC_ADDR_PAUSE_CNT 8'h48
`define MPFC_ADDR_CTRL_CNT 8'h4c

// Field positions inside the control register.
`define MPFC_CTRL_WAIT_ACK_BIT 0
`define MPFC_CTRL_PASS_CTRL_BIT 1

// Reset values of the settings.
`define MPFC_RST_CTRL_TYPE 16'h8808
`define MPFC_RST_OPCODE_LOW 16'h0000
`define MPFC_RST_OPCODE_HIGH 16'hfff
`define MPFC_RST_PAUSE_OPCODE 16'h0001
`define MPFC_RST_PAUSE_MCAST 48'h0180c2000001
`define MPFC_RST_SRC_ADDR 48'h000000000000
`define MPFC_RST_WAIT_ACK 1'b1
`define MPFC_RST_PASS_CTRL 1'b0

// Bit of the pause request vector that stands for a global pause.
`define MPFC_GLOBAL_BIT 8

`endif

// ==== hdl/mpfc_pkg.sv ====
package mpfc_pkg;

   // Header fields of a received frame, presented for one cycle.
   typedef struct packed {
      logic valid;
      logic [47:0] dest_addr;
      logic [15:0] ethertype;
      logic [15:0] opcode;
      logic [7:0] class_enable;
   } mpfc_rx_hdr_type;

   // Classification result of one received frame.
   typedef struct packed {
      logic valid;
      logic prio_ctrl;
      logic global_pause;
      logic prio_pause;
      logic control;
      logic forward;
   } mpfc_rx_class_type;

   // Request to generate one pause frame.
   typedef struct packed {
      logic valid;
      logic is_prio;
      logic [7:0] class_enable;
   } mpfc_tx_req_type;

   // Header fields of a generated pause frame.
   typedef struct packed {
      logic valid;
      logic is_prio;
      logic [47:0] dest_addr;
      logic [47:0] src_addr;
      logic [15:0] ethertype;
      logic [15:0] opcode;
      logic [7:0] class_enable;
   } mpfc_tx_hdr_type;

   // Address and type fields of one kind of generated pause frame.
   typedef struct packed {
      logic [47:0] dest_addr;
      logic [47:0] src_addr;
      logic [15:0] ethertype;
      logic [15:0] opcode;
   } mpfc_tx_fields_type;

   // All software settings.
   typedef struct packed {
      logic [15:0] pcp_type;
      logic [15:0] pcp_op_low;
      logic [15:0] pcp_op_high;
      logic [15:0] gpp_type;
      logic [15:0] gpp_op;
      logic [15:0] ppp_type;
      logic [15:0] ppp_op;
      logic wait_ack;
      logic pass_ctrl;
      logic [47:0] mcast_addr;
      mpfc_tx_fields_type tx_gpp;
      mpfc_tx_fields_type tx_ppp;
   } mpfc_cfg_type;

   // Whole state of the block.
   typedef struct packed {
      mpfc_cfg_type cfg;
      logic [31:0] rd_data;
      mpfc_rx_class_type rx_class;
      logic [8:0] pause_req;
      logic [15:0] pause_cnt;
      logic [15:0] drop_cnt;
      logic [15:0] ctrl_cnt;
      mpfc_tx_hdr_type tx_hdr;
   } mpfc_state_type;

endpackage

// ==== hdl/mpfc_field_match.sv ====
`timescale 1ns/10ps

// Compares a frame's type and opcode with one configured pair.
module mpfc_field_match #(
   parameter int WIDTH = 16
) (
   input wire logic [WIDTH-1:0] frame_type, // Type field of the frame.
   input wire logic [WIDTH-1:0] frame_op, // Opcode field of the frame.
   input wire logic [WIDTH-1:0] cfg_type, // Configured type value.
   input wire logic [WIDTH-1:0] cfg_op, // Configured opcode value.
   output logic hit // Both fields are equal.
);

   // Both fields must agree exactly.
   assign hit = (frame_type == cfg_type) && (frame_op == cfg_op);

endmodule

// ==== hdl/mpfc_top.sv ====
// Functional notes
// R1: Priority control frames are found by comparing Ethertype with a settable 16-bit value.
// R2: Priority control frames need opcode within the settable inclusive low/high range.
// R3: Global pause means Ethertype and opcode both equal their settable values.
// R4: Priority pause means Ethertype and opcode equal their own settable values.
// R5: With acknowledge wait set, user ack clears pause requests; otherwise ack ignored.
// R6: Control frames are passed to the user when forwarding is set, else dropped.
// R7: Generated global pause carries settable destination, Ethertype and opcode.
// R8: Generated global pause carries a settable source address, default zero.
// R9: Generated priority pause carries its own destination, Ethertype and opcode.
// R10: Generated priority pause carries its own source address, default zero.
// R11: Pause frames must also match the settable multicast destination address.
// R12: Integrating logic keeps all settings steady while the MAC runs.
//
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/10ps
`include "mpfc_consts.svh"

module mpfc_top (
   input wire logic MCLK, // System clock, 40 MHz.
   input wire logic RST_B, // Asynchronous reset, active low.
   input wire logic [7:0] ADDR, // Register byte address.
   input wire logic [31:0] WDATA, // Register write data.
   input wire logic WR_STB, // Register write strobe.
   input wire logic RD_STB, // Register read strobe.
   output logic [31:0] RDATA, // Read data, valid the cycle after RD_STB.
   input wire mpfc_pkg::mpfc_rx_hdr_type RX_HDR, // Received frame header.
   input wire logic [8:0] RX_USER_ACK, // User acknowledge of pause requests.
   output mpfc_pkg::mpfc_rx_class_type RX_CLASS, // Frame classification.
   output logic [8:0] RX_PAUSE_REQ, // Pause requests, bit 8 global.
   input wire mpfc_pkg::mpfc_tx_req_type TX_REQ, // Pause generation request.
   output mpfc_pkg::mpfc_tx_hdr_type TX_HDR // Generated pause header.
);
   import mpfc_pkg::*;

   mpfc_state_type state_r;
   mpfc_state_type state_nxt;
   logic gpp_hit;
   logic ppp_hit;
   logic pcp_type_hit;
   logic pcp_range_hit;
   logic mcast_hit;
   logic prio_ctrl;
   logic is_control;
   logic pause_ok;

   ////////////////////////////////////////////////////////////////////////////
   // Frame classification.
   ////////////////////////////////////////////////////////////////////////////

   // Global pause type and opcode compare.
   mpfc_field_match #(
      .WIDTH(16)
   ) u_gpp_match (
      .frame_type(RX_HDR.ethertype),
      .frame_op(RX_HDR.opcode),
      .cfg_type(state_r.cfg.gpp_type),
      .cfg_op(state_r.cfg.gpp_op),
      .hit(gpp_hit) // R3
   );

   // Priority pause type and opcode compare.
   mpfc_field_match #(
      .WIDTH(16)
   ) u_ppp_match (
      .frame_type(RX_HDR.ethertype),
      .frame_op(RX_HDR.opcode),
      .cfg_type(state_r.cfg.ppp_type),
      .cfg_op(state_r.cfg.ppp_op),
      .hit(ppp_hit) // R4
   );

   // Priority control frames match the type and fall inside the opcode range.
   assign pcp_type_hit = RX_HDR.ethertype == state_r.cfg.pcp_type; // R1
   assign pcp_range_hit = (RX_HDR.opcode >= state_r.cfg.pcp_op_low) &&
                          (RX_HDR.opcode <= state_r.cfg.pcp_op_high); // R2
   assign prio_ctrl = pcp_type_hit && pcp_range_hit;

   // A pause only takes effect when addressed to the pause multicast address.
   assign mcast_hit = RX_HDR.dest_addr == state_r.cfg.mcast_addr; // R11
   assign pause_ok = RX_HDR.valid && mcast_hit;

   // Any of the three kinds makes the frame a control frame.
   assign is_control = prio_ctrl || gpp_hit || ppp_hit;

   ////////////////////////////////////////////////////////////////////////////
   // Next state.
   ////////////////////////////////////////////////////////////////////////////

   // Register writes, register reads, classification, pause and generation.
   always_comb begin
      state_nxt = state_r;

      // Settings are written here; the far side keeps them still while running.
      if (WR_STB) begin // R12
         case (ADDR)
            `MPFC_ADDR_RX_PCP_TYPE: begin
               state_nxt.cfg.pcp_type = WDATA[15:0]; // R1
            end
            `MPFC_ADDR_RX_PCP_RANGE: begin
               state_nxt.cfg.pcp_op_low = WDATA[15:0]; // R2
               state_nxt.cfg.pcp_op_high = WDATA[31:16]; // R2
            end
            `MPFC_ADDR_RX_GPP: begin
               state_nxt.cfg.gpp_type = WDATA[15:0]; // R3
               state_nxt.cfg.gpp_op = WDATA[31:16]; // R3
            end
            `MPFC_ADDR_RX_PPP: begin
               state_nxt.cfg.ppp_type = WDATA[15:0]; // R4
               state_nxt.cfg.ppp_op = WDATA[31:16]; // R4
            end
            `MPFC_ADDR_CTRL: begin
               state_nxt.cfg.wait_ack = WDATA[`MPFC_CTRL_WAIT_ACK_BIT]; // R5
               state_nxt.cfg.pass_ctrl = WDATA[`MPFC_CTRL_PASS_CTRL_BIT]; // R6
            end
            `MPFC_ADDR_RX_MCAST_LO: begin
               state_nxt.cfg.mcast_addr[31:0] = WDATA; // R11
            end
            `MPFC_ADDR_RX_MCAST_HI: begin
               state_nxt.cfg.mcast_addr[47:32] = WDATA[15:0]; // R11
            end
            `MPFC_ADDR_TX_GPP_DA_LO: begin
               state_nxt.cfg.tx_gpp.dest_addr[31:0] = WDATA; // R7
            end
            `MPFC_ADDR_TX_GPP_DA_HI: begin
               state_nxt.cfg.tx_gpp.dest_addr[47:32] = WDATA[15:0]; // R7
            end
            `MPFC_ADDR_TX_GPP_SA_LO: begin
               state_nxt.cfg.tx_gpp.src_addr[31:0] = WDATA; // R8
            end
            `MPFC_ADDR_TX_GPP_SA_HI: begin
               state_nxt.cfg.tx_gpp.src_addr[47:32] = WDATA[15:0]; // R8
            end
            `MPFC_ADDR_TX_GPP_TYPE: begin
               state_nxt.cfg.tx_gpp.ethertype = WDATA[15:0]; // R7
               state_nxt.cfg.tx_gpp.opcode = WDATA[31:16]; // R7
            end
            `MPFC_ADDR_TX_PPP_DA_LO: begin
               state_nxt.cfg.tx_ppp.dest_addr[31:0] = WDATA; // R9
            end
            `MPFC_ADDR_TX_PPP_DA_HI: begin
               state_nxt.cfg.tx_ppp.dest_addr[47:32] = WDATA[15:0]; // R9
            end
            `MPFC_ADDR_TX_PPP_SA_LO: begin
               state_nxt.cfg.tx_ppp.src_addr[31:0] = WDATA; // R10
            end
            `MPFC_ADDR_TX_PPP_SA_HI: begin
               state_nxt.cfg.tx_ppp.src_addr[47:32] = WDATA[15:0]; // R10
            end
            `MPFC_ADDR_TX_PPP_TYPE: begin
               state_nxt.cfg.tx_ppp.ethertype = WDATA[15:0]; // R9
               state_nxt.cfg.tx_ppp.opcode = WDATA[31:16]; // R9
            end
            default: begin
               state_nxt.cfg = state_r.cfg;
            end
         endcase
      end

      // Read data stand for exactly one cycle; unmapped addresses read zero.
      state_nxt.rd_data = 32'h0;
      if (RD_STB) begin
         case (ADDR)
            `MPFC_ADDR_RX_PCP_TYPE: begin
               state_nxt.rd_data = {16'h0, state_r.cfg.pcp_type};
            end
            `MPFC_ADDR_RX_PCP_RANGE: begin
               state_nxt.rd_data = {state_r.cfg.pcp_op_high, state_r.cfg.pcp_op_low};
            end
            `MPFC_ADDR_RX_GPP: begin
               state_nxt.rd_data = {state_r.cfg.gpp_op, state_r.cfg.gpp_type};
            end
            `MPFC_ADDR_RX_PPP: begin
               state_nxt.rd_data = {state_r.cfg.ppp_op, state_r.cfg.ppp_type};
            end
            `MPFC_ADDR_CTRL: begin
               state_nxt.rd_data = {30'h0, state_r.cfg.pass_ctrl, state_r.cfg.wait_ack};
            end
            `MPFC_ADDR_RX_MCAST_LO: begin
               state_nxt.rd_data = state_r.cfg.mcast_addr[31:0];
            end
            `MPFC_ADDR_RX_MCAST_HI: begin
               state_nxt.rd_data = {16'h0, state_r.cfg.mcast_addr[47:32]};
            end
            `MPFC_ADDR_TX_GPP_DA_LO: begin
               state_nxt.rd_data = state_r.cfg.tx_gpp.dest_addr[31:0];
            end
            `MPFC_ADDR_TX_GPP_DA_HI: begin
               state_nxt.rd_data = {16'h0, state_r.cfg.tx_gpp.dest_addr[47:32]};
            end
            `MPFC_ADDR_TX_GPP_SA_LO: begin
               state_nxt.rd_data = state_r.cfg.tx_gpp.src_addr[31:0];
            end
            `MPFC_ADDR_TX_GPP_SA_HI: begin
               state_nxt.rd_data = {16'h0, state_r.cfg.tx_gpp.src_addr[47:32]};
            end
            `MPFC_ADDR_TX_GPP_TYPE: begin
               state_nxt.rd_data = {state_r.cfg.tx_gpp.opcode, state_r.cfg.tx_gpp.ethertype};
            end
            `MPFC_ADDR_TX_PPP_DA_LO: begin
               state_nxt.rd_data = state_r.cfg.tx_ppp.dest_addr[31:0];
            end
            `MPFC_ADDR_TX_PPP_DA_HI: begin
               state_nxt.rd_data = {16'h0, state_r.cfg.tx_ppp.dest_addr[47:32]};
            end
            `MPFC_ADDR_TX_PPP_SA_LO: begin
               state_nxt.rd_data = state_r.cfg.tx_ppp.src_addr[31:0];
            end
            `MPFC_ADDR_TX_PPP_SA_HI: begin
               state_nxt.rd_data = {16'h0, state_r.cfg.tx_ppp.src_addr[47:32]};
            end
            `MPFC_ADDR_TX_PPP_TYPE: begin
               state_nxt.rd_data = {state_r.cfg.tx_ppp.opcode, state_r.cfg.tx_ppp.ethertype};
            end
            `MPFC_ADDR_STATUS: begin
               state_nxt.rd_data = {23'h0, state_r.pause_req};
            end
            `MPFC_ADDR_PAUSE_CNT: begin
               state_nxt.rd_data = {state_r.drop_cnt, state_r.pause_cnt};
            end
            `MPFC_ADDR_CTRL_CNT: begin
               state_nxt.rd_data = {16'h0, state_r.ctrl_cnt};
            end
            default: begin
               state_nxt.rd_data = 32'h0;
            end
         endcase
      end

      // Classification result stands for one cycle per received header.
      state_nxt.rx_class = '0;
      if (RX_HDR.valid) begin
         state_nxt.rx_class.valid = 1'b1;
         state_nxt.rx_class.prio_ctrl = prio_ctrl; // R1
         state_nxt.rx_class.global_pause = gpp_hit; // R3
         state_nxt.rx_class.prio_pause = ppp_hit; // R4
         state_nxt.rx_class.control = is_control;
         state_nxt.rx_class.forward = !is_control || state_r.cfg.pass_ctrl; // R6
      end

      // Counters of control frames seen, qualified pauses and dropped frames.
      if (RX_HDR.valid && is_control) begin
         state_nxt.ctrl_cnt = state_r.ctrl_cnt + 16'h1;
         if (!state_r.cfg.pass_ctrl) begin
            state_nxt.drop_cnt = state_r.drop_cnt + 16'h1; // R6
         end
      end
      if (pause_ok && (gpp_hit || ppp_hit)) begin
         state_nxt.pause_cnt = state_r.pause_cnt + 16'h1; // R11
      end

      // Pause requests: held until acknowledged, or one-cycle pulses.
      if (state_r.cfg.wait_ack) begin
         state_nxt.pause_req = state_r.pause_req & ~RX_USER_ACK; // R5
      end else begin
         state_nxt.pause_req = 9'h0; // R5
      end
      // A new pause sets its bit and wins over an acknowledge in the same cycle.
      if (pause_ok && gpp_hit) begin
         state_nxt.pause_req[`MPFC_GLOBAL_BIT] = 1'b1; // R11
      end
      if (pause_ok && ppp_hit) begin
         state_nxt.pause_req[7:0] = state_nxt.pause_req[7:0] | RX_HDR.class_enable; // R11
      end

      // Generated pause header, one cycle after the request.
      state_nxt.tx_hdr = '0;
      if (TX_REQ.valid) begin
         state_nxt.tx_hdr.valid = 1'b1;
         state_nxt.tx_hdr.is_prio = TX_REQ.is_prio;
         state_nxt.tx_hdr.class_enable = TX_REQ.class_enable;
         if (TX_REQ.is_prio) begin
            state_nxt.tx_hdr.dest_addr = state_r.cfg.tx_ppp.dest_addr; // R9
            state_nxt.tx_hdr.src_addr = state_r.cfg.tx_ppp.src_addr; // R10
            state_nxt.tx_hdr.ethertype = state_r.cfg.tx_ppp.ethertype; // R9
            state_nxt.tx_hdr.opcode = state_r.cfg.tx_ppp.opcode; // R9
         end else begin
            state_nxt.tx_hdr.dest_addr = state_r.cfg.tx_gpp.dest_addr; // R7
            state_nxt.tx_hdr.src_addr = state_r.cfg.tx_gpp.src_addr; // R8
            state_nxt.tx_hdr.ethertype = state_r.cfg.tx_gpp.ethertype; // R7
            state_nxt.tx_hdr.opcode = state_r.cfg.tx_gpp.opcode; // R7
            state_nxt.tx_hdr.class_enable = 8'h0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register.
   ////////////////////////////////////////////////////////////////////////////

   // Reset loads the default settings and clears all activity.
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         state_r <= '0;
         state_r.cfg.pcp_type <= `MPFC_RST_CTRL_TYPE; // R1
         state_r.cfg.pcp_op_low <= `MPFC_RST_OPCODE_LOW; // R2
         state_r.cfg.pcp_op_high <= `MPFC_RST_OPCODE_HIGH; // R2
         state_r.cfg.gpp_type <= `MPFC_RST_CTRL_TYPE; // R3
         state_r.cfg.gpp_op <= `MPFC_RST_PAUSE_OPCODE; // R3
         state_r.cfg.ppp_type <= `MPFC_RST_CTRL_TYPE; // R4
         state_r.cfg.ppp_op <= `MPFC_RST_PAUSE_OPCODE; // R4
         state_r.cfg.wait_ack <= `MPFC_RST_WAIT_ACK; // R5
         state_r.cfg.pass_ctrl <= `MPFC_RST_PASS_CTRL; // R6
         state_r.cfg.mcast_addr <= `MPFC_RST_PAUSE_MCAST; // R11
         state_r.cfg.tx_gpp.dest_addr <= `MPFC_RST_PAUSE_MCAST; // R7
         state_r.cfg.tx_gpp.src_addr <= `MPFC_RST_SRC_ADDR; // R8
         state_r.cfg.tx_gpp.ethertype <= `MPFC_RST_CTRL_TYPE; // R7
         state_r.cfg.tx_gpp.opcode <= `MPFC_RST_PAUSE_OPCODE; // R7
         state_r.cfg.tx_ppp.dest_addr <= `MPFC_RST_PAUSE_MCAST; // R9
         state_r.cfg.tx_ppp.src_addr <= `MPFC_RST_SRC_ADDR; // R10
         state_r.cfg.tx_ppp.ethertype <= `MPFC_RST_CTRL_TYPE; // R9
         state_r.cfg.tx_ppp.opcode <= `MPFC_RST_PAUSE_OPCODE; // R9
      end else begin
         state_r <= state_nxt;
      end
   end

   // Outputs come straight from the state register.
   assign RDATA = state_r.rd_data;
   assign RX_CLASS = state_r.rx_class;
   assign RX_PAUSE_REQ = state_r.pause_req;
   assign TX_HDR = state_r.tx_hdr;

endmodule

// ==== test/mpfc_top_sva.sv ====
`timescale 1ns/10ps

// Watches the port timing and flag relations of the pause configuration block.
module mpfc_top_sva
   import mpfc_pkg::*;
(
   input wire logic MCLK, // Clock.
   input wire logic RST_B, // Reset, active low.
   input wire mpfc_pkg::mpfc_rx_hdr_type RX_HDR, // Received header.
   input wire logic [8:0] RX_USER_ACK, // User acknowledge.
   input wire mpfc_pkg::mpfc_rx_class_type RX_CLASS, // Classification.
   input wire logic [8:0] RX_PAUSE_REQ, // Pause requests.
   input wire mpfc_pkg::mpfc_tx_req_type TX_REQ, // Generation request.
   input wire mpfc_pkg::mpfc_tx_hdr_type TX_HDR // Generated header.
);
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (!RST_B);

   ////////////////////////////////////////////////////////////////////////////////
   a_class_follows: assert property (RX_HDR.valid |=> RX_CLASS.valid)
      else $error("classification missing after header");
   a_class_idle: assert property (!RX_HDR.valid |=> RX_CLASS == '0)
      else $error("classification without header");
   a_ctrl_union: assert property (RX_CLASS.valid |-> RX_CLASS.control ==
      (RX_CLASS.prio_ctrl | RX_CLASS.global_pause | RX_CLASS.prio_pause))
      else $error("control flag disagrees with kinds");
   a_fwd_plain: assert property (RX_CLASS.valid && !RX_CLASS.control |-> RX_CLASS.forward)
      else $error("plain frame not forwarded");
   a_ack_clears: assert property (RX_PAUSE_REQ[8] && RX_USER_ACK[8] && !RX_HDR.valid
      |=> !RX_PAUSE_REQ[8])
      else $error("global request survives acknowledge");
   a_req_cause: assert property ($rose(RX_PAUSE_REQ[8])
      |-> $past(RX_HDR.valid) && RX_CLASS.global_pause)
      else $error("global request without global pause frame");
   a_tx_kind: assert property (TX_REQ.valid
      |=> TX_HDR.valid && TX_HDR.is_prio == $past(TX_REQ.is_prio))
      else $error("generated header missing or wrong kind");
   a_tx_classes: assert property (TX_REQ.valid |=> TX_HDR.class_enable ==
      ($past(TX_REQ.is_prio) ? $past(TX_REQ.class_enable) : 8'h00))
      else $error("generated class enables wrong");
   a_tx_idle: assert property (!TX_REQ.valid |=> TX_HDR == '0)
      else $error("generated header without request");
endmodule

bind mpfc_top mpfc_top_sva chk (.MCLK(MCLK), .RST_B(RST_B), .RX_HDR(RX_HDR),
   .RX_USER_ACK(RX_USER_ACK), .RX_CLASS(RX_CLASS), .RX_PAUSE_REQ(RX_PAUSE_REQ),
   .TX_REQ(TX_REQ), .TX_HDR(TX_HDR));

// ==== test/mpfc_link_model.sv ====
`timescale 1ns/10ps

// Far side: the link partner's received headers and the user's acknowledges.
module mpfc_link_model
   import mpfc_pkg::*;
(
   input wire logic MCLK, // Clock.
   output mpfc_pkg::mpfc_rx_hdr_type RX_HDR, // Header toward the block.
   output logic [8:0] RX_USER_ACK, // User acknowledge.
   input wire mpfc_pkg::mpfc_tx_hdr_type TX_HDR // Generated header, observed only.
);
   // Idle values at time zero.
   initial begin
      RX_HDR = '0;
      RX_USER_ACK = '0;
   end

   // Shows one header for one cycle; released fields are inverted so stale data never match.
   task automatic send(input logic [47:0] da, input logic [15:0] et, input logic [15:0] op,
                       input logic [7:0] ce);
      @(posedge MCLK);
      RX_HDR <= '{1'b1, da, et, op, ce};
      @(posedge MCLK);
      RX_HDR <= '{1'b0, ~da, ~et, ~op, ~ce};
   endtask

   // Raises acknowledge bits for one cycle.
   task automatic ack(input logic [8:0] bits);
      @(posedge MCLK);
      RX_USER_ACK <= bits;
      @(posedge MCLK);
      RX_USER_ACK <= '0;
   endtask
endmodule

// ==== test/tb.sv ====
`timescale 1ns/10ps
`include "mpfc_consts.svh"

// Self-checking bench of the pause configuration block.
module tb;
   import mpfc_pkg::*;
   localparam logic [47:0] MC = 48'h0180c2000001;
   logic MCLK = 1'b0;
   logic RST_B = 1'b0;
   logic [7:0] ADDR = 8'h00;
   logic [31:0] WDATA = 32'h0;
   logic WR_STB = 1'b0;
   logic RD_STB = 1'b0;
   logic [31:0] RDATA;
   mpfc_rx_hdr_type RX_HDR;
   logic [8:0] RX_USER_ACK;
   mpfc_rx_class_type RX_CLASS;
   logic [8:0] RX_PAUSE_REQ;
   mpfc_tx_req_type TX_REQ = '0;
   mpfc_tx_hdr_type TX_HDR;
   int n_fail = 0;
   int n_compared = 0;
   logic [31:0] dflt [21] = '{32'h8808, 32'h0fff0000, 32'h18808, 32'h18808, 32'h1,
      32'hc2000001, 32'h180, 32'hc2000001, 32'h180, 32'h0, 32'h0, 32'h18808, 32'hc2000001,
      32'h180, 32'h0, 32'h0, 32'h18808, 32'h0, 32'h0, 32'h0, 32'h0};
   logic [15:0] f_et [10] = '{16'h8808, 16'h8808, 16'h8808, 16'h8809, 16'h88aa, 16'h88aa,
      16'h88aa, 16'h88aa, 16'h1234, 16'h5678};
   logic [15:0] f_op [10] = '{16'h1, 16'hfff, 16'h1000, 16'h1, 16'h4, 16'h5, 16'h7, 16'h8,
      16'h2, 16'h3};
   logic [5:0] f_cls [10] = '{6'h3e, 6'h32, 6'h21, 6'h21, 6'h21, 6'h33, 6'h33, 6'h21,
      6'h2b, 6'h27};
   logic [31:0] tx_cfg [10] = '{32'h44332211, 32'h6655, 32'hccbbaa99, 32'heedd, 32'h99100,
      32'h01020304, 32'h0506, 32'h0a0b0c0d, 32'h0e0f, 32'h01018899};

   // Clock of 25 ns period.
   always #12.5 MCLK = ~MCLK;

   mpfc_top uut (.MCLK(MCLK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA), .WR_STB(WR_STB),
      .RD_STB(RD_STB), .RDATA(RDATA), .RX_HDR(RX_HDR), .RX_USER_ACK(RX_USER_ACK),
      .RX_CLASS(RX_CLASS), .RX_PAUSE_REQ(RX_PAUSE_REQ), .TX_REQ(TX_REQ), .TX_HDR(TX_HDR));
   mpfc_link_model lnk (.MCLK(MCLK), .RX_HDR(RX_HDR), .RX_USER_ACK(RX_USER_ACK),
      .TX_HDR(TX_HDR));

   ////////////////////////////////////////////////////////////////////////////////
   // Compares a register word.
   task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Compares a structured port output.
   task automatic chk_out(input string nm, input logic [139:0] e, input logic [139:0] g);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One write cycle on the register port.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge MCLK);
      ADDR <= a;
      WDATA <= d;
      WR_STB <= 1'b1;
      @(posedge MCLK);
      WR_STB <= 1'b0;
   endtask

   // One read cycle; the data are judged in the cycle after the strobe.
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge MCLK);
      ADDR <= a;
      RD_STB <= 1'b1;
      @(posedge MCLK);
      RD_STB <= 1'b0;
      #1 chk_reg($sformatf("reg %h", a), e, RDATA);
   endtask

   // Sends frames from the table to the multicast address and judges their classes.
   task automatic run_frames(input int lo, input int hi);
      for (int i = lo; i <= hi; i++) begin
         lnk.send(MC, f_et[i], f_op[i], 8'h00);
         #1 chk_out($sformatf("class %0d", i), f_cls[i], RX_CLASS);
      end
   endtask

   // Back-to-back global and priority generation requests.
   task automatic tx_pair(input mpfc_tx_hdr_type eg, input mpfc_tx_hdr_type ep);
      @(posedge MCLK);
      TX_REQ <= '{1'b1, 1'b0, 8'h5a};
      @(posedge MCLK);
      TX_REQ <= '{1'b1, 1'b1, 8'ha5};
      #1 chk_out("tx global", eg, TX_HDR);
      @(posedge MCLK);
      TX_REQ <= '0;
      #1 chk_out("tx prio", ep, TX_HDR);
      @(posedge MCLK);
      #1 chk_out("tx idle", '0, TX_HDR);
   endtask

   // Pause requests: held until acknowledged, address check, then pulse mode.
   task automatic t_pause;
      lnk.send(MC, 16'h8808, 16'h0001, 8'ha5);
      #1 chk_out("req set", 9'h1a5, RX_PAUSE_REQ);
      repeat (3) @(posedge MCLK);
      #1 chk_out("req held", 9'h1a5, RX_PAUSE_REQ);
      rd(`MPFC_ADDR_STATUS, 32'h000001a5);
      lnk.ack(9'h100);
      #1 chk_out("req ack global", 9'h0a5, RX_PAUSE_REQ);
      lnk.ack(9'h0a5);
      #1 chk_out("req ack prio", 9'h000, RX_PAUSE_REQ);
      lnk.send(48'h0180c2000002, 16'h8808, 16'h0001, 8'hff);
      #1 chk_out("req wrong da", 9'h000, RX_PAUSE_REQ);
      wr(`MPFC_ADDR_CTRL, 32'h2);
      lnk.send(MC, 16'h8808, 16'h0001, 8'h3c);
      #1 chk_out("class fwd", 6'h3f, RX_CLASS);
      chk_out("req pulse", 9'h13c, RX_PAUSE_REQ);
      @(posedge MCLK);
      #1 chk_out("req pulse end", 9'h000, RX_PAUSE_REQ);
   endtask

   // Watchdog against a hang.
   initial begin
      repeat (5000) @(posedge MCLK);
      n_fail++;
      test_done();
   end

   // Prints the counts and the verdict, then ends the run.
   task automatic test_done;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Main sequence.
   initial begin
      repeat (12) @(posedge MCLK);
      RST_B <= 1'b1;
      for (int i = 0; i < 21; i++) rd(8'(i * 4), dflt[i]);
      run_frames(0, 3);
      tx_pair('{1'b1, 1'b0, MC, 48'h0, 16'h8808, 16'h0001, 8'h00},
              '{1'b1, 1'b1, MC, 48'h0, 16'h8808, 16'h0001, 8'ha5});
      t_pause();
      wr(`MPFC_ADDR_RX_PCP_TYPE, 32'h88aa);
      wr(`MPFC_ADDR_RX_PCP_RANGE, 32'h00070005);
      wr(`MPFC_ADDR_RX_GPP, 32'h00021234);
      wr(`MPFC_ADDR_RX_PPP, 32'h00035678);
      run_frames(4, 9);
      for (int i = 0; i < 10; i++) wr(8'(8'h1c + i * 4), tx_cfg[i]);
      tx_pair('{1'b1, 1'b0, 48'h665544332211, 48'heeddccbbaa99, 16'h9100, 16'h0009, 8'h00},
              '{1'b1, 1'b1, 48'h050601020304, 48'h0e0f0a0b0c0d, 16'h8899, 16'h0101,
                8'ha5});
      wr(`MPFC_ADDR_RX_MCAST_LO, 32'hc2000002);
      lnk.send(48'h0180c2000002, 16'h1234, 16'h0002, 8'h00);
      #1 chk_out("req new da", 9'h100, RX_PAUSE_REQ);
      lnk.send(MC, 16'h1234, 16'h0002, 8'h00);
      #1 chk_out("req old da", 9'h000, RX_PAUSE_REQ);
      rd(`MPFC_ADDR_PAUSE_CNT, 32'h00040006);
      rd(`MPFC_ADDR_CTRL_CNT, 32'h0000000b);
      test_done();
   end
endmodule
